// file: hw/regulator_mode_sequencer.sv
// Implementation choices: the AHB-Lite register port and the register offsets.
`include "regulator_mode_sequencer_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module regulator_mode_sequencer #(
    parameter int unsigned ANALOG_CYC    = `ANALOG_DELAY_CYC,
    parameter int unsigned CLOCK_ENABLE_N_CYC     = `CLOCK_ENABLE_N_DELAY_CYC,
    parameter int unsigned PGOOD_CPU_CYC = `PGOOD_CPU_DELAY_CYC,
    parameter int unsigned PGOOD_GFX_CYC = `PGOOD_GFX_DELAY_CYC
) (
    input  wire logic                                hclk,
    input  wire logic                                hresetn,
    input  wire logic                                clk_en,
    input  wire logic                                hsel,
    input  wire logic [7:0]                          haddr,
    input  wire logic [1:0]                          htrans,
    input  wire logic                                hwrite,
    input  wire logic [2:0]                          hsize,
    input  wire logic [31:0]                         hwdata,
    input  wire logic                                hready,
    output logic [31:0]                              hrdata,
    output logic                                     hreadyout,
    output logic                                     hresp,
    input  wire logic                                shutdown_n,
    input  wire logic                                deep_sleep_request,
    input  wire logic                                deep_stop_request,
    input  wire logic                                profile_select,
    input  wire logic                                supply_lockout,
    input  wire logic                                at_target,
    input  wire logic                                at_zero,
    input  wire logic                                in_regulation,
    input  wire logic                                zero_current,
    input  wire logic                                pwm_high_req,
    input  wire regulator_mode_sequencer_pkg::fault_in_t faults,
    output logic                                     high_side_gate,
    output logic                                     low_side_gate,
    output logic                                     power_good_out,
    output logic                                     power_good_oe,
    output logic                                     clock_enable_n,
    output logic                                     clock_enable_oe,
    output regulator_mode_sequencer_pkg::drive_cfg_t drive_cfg,
    output regulator_mode_sequencer_pkg::power_en_t  power_en,
    output logic [15:0]                              start_target_mv,
    output regulator_mode_sequencer_pkg::reg_mode_t  mode
);
    import regulator_mode_sequencer_pkg::*;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic        ph_valid;
    logic        ph_write;
    logic [7:0]  ph_addr;
    logic        no_fault;
    logic        fault_latch;
    logic        fault_clr_pulse;
    logic        shutdown_n_prev;
    logic        cpu_profile;
    logic [22:0] timer;
    logic        clock_enable_n_on;
    logic        pgood_rel;
    logic        skip_blank;

    function automatic logic [31:0] read_mux(input logic [7:0] a);
        unique case (a)
            `REG_CTRL_ADDR:   read_mux = {30'h0, 1'b0, no_fault};
            `REG_STATUS_ADDR: read_mux = {16'h0, fault_latch, cpu_profile,
                                          pgood_rel, clock_enable_n_on,
                                          skip_blank, 3'h0, mode};
            `REG_THRESH_ADDR: read_mux = {12'h0, drive_cfg.slew_div,
                                          start_target_mv};
            default:          read_mux = 32'h0;
        endcase
    endfunction

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr  <= 8'h00;
        end else if (clk_en && hready) begin
            ph_valid <= hsel && htrans[1];
            ph_write <= hwrite;
            ph_addr  <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (clk_en && hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= read_mux(haddr);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            no_fault        <= 1'(`REG_CTRL_RESET);
            fault_clr_pulse <= 1'b0;
        end else if (clk_en) begin
            fault_clr_pulse <= 1'b0;
            if (ph_valid && ph_write && ph_addr == `REG_CTRL_ADDR) begin
                no_fault        <= hwdata[`CTRL_NO_FAULT_BIT];
                fault_clr_pulse <= hwdata[`CTRL_FAULT_CLR_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // fault latch
    // ------------------------------------------------------------
    logic fault_event;
    logic shutdown_n_fall;
    logic shutdown_n_rise;

    // startup regulation failure reaches us as the undervoltage trip
    assign fault_event = !no_fault && (|faults) && shutdown_n;
    assign shutdown_n_fall   = shutdown_n_prev && !shutdown_n;
    assign shutdown_n_rise   = !shutdown_n_prev && shutdown_n;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shutdown_n_prev <= 1'b0;
        end else if (clk_en) begin
            shutdown_n_prev <= shutdown_n;
        end
    end

    // hresetn stands for power-on reset: clears the latch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_latch <= 1'b0;
        end else if (clk_en) begin
            if (fault_event) begin
                fault_latch <= 1'b1;
            end else if (shutdown_n_fall || no_fault || fault_clr_pulse) begin
                fault_latch <= 1'b0;
            end
        end
    end

    // profile strap sampled on every cycle while in MODE_DISABLED
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_profile <= 1'b0;
        end else if (clk_en && mode == MODE_DISABLED) begin
            cpu_profile <= profile_select;
        end
    end

    // ------------------------------------------------------------
    // mode sequencer
    // ------------------------------------------------------------
    logic      ref_up;
    reg_mode_t next_mode;

    always_comb begin
        next_mode = mode;
        if (fault_latch || fault_event) begin
            next_mode = MODE_FAULT;
        end else if (supply_lockout) begin
            next_mode = MODE_DISABLED;
        end else begin
            unique case (mode)
                MODE_DISABLED: begin
                    if (shutdown_n) next_mode = MODE_POWERUP;
                end
                MODE_POWERUP: begin
                    if (!shutdown_n) next_mode = MODE_DISABLED;
                    else if (ref_up && timer >= 23'(ANALOG_CYC))
                        next_mode = MODE_STARTUP;
                end
                MODE_STARTUP: begin
                    if (!shutdown_n) next_mode = MODE_SHUTDOWN;
                    else if (at_target) next_mode = MODE_BOOT_WAIT;
                end
                MODE_BOOT_WAIT: begin
                    if (!shutdown_n) next_mode = MODE_SHUTDOWN;
                    else if (cpu_profile ? clock_enable_n_on : pgood_rel)
                        next_mode = MODE_RUN;
                end
                MODE_RUN: begin
                    if (!shutdown_n) next_mode = MODE_SHUTDOWN;
                end
                MODE_SHUTDOWN: begin
                    if (at_zero) next_mode = MODE_DISABLED;
                    else if (shutdown_n_rise) next_mode = MODE_POWERUP;
                end
                MODE_FAULT: begin
                    next_mode = MODE_DISABLED;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode <= MODE_DISABLED;
        end else if (clk_en) begin
            mode <= next_mode;
        end
    end

    // single timer restarted on each mode change
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer <= 23'h0;
        end else if (clk_en) begin
            if (next_mode != mode) begin
                timer <= 23'h0;
            end else if (timer != 23'h7fffff) begin
                timer <= timer + 23'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_up <= 1'b0;
        end else if (clk_en) begin
            ref_up <= (mode == MODE_POWERUP) && shutdown_n;
        end
    end

    // ------------------------------------------------------------
    // power-good / clock-enable timing
    // ------------------------------------------------------------
    logic [22:0] pg_timer;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clock_enable_n_on <= 1'b0;
            pgood_rel <= 1'b0;
            pg_timer  <= 23'h0;
        end else if (clk_en) begin
            if (!shutdown_n || mode == MODE_FAULT
                || mode == MODE_DISABLED || mode == MODE_POWERUP
                || mode == MODE_STARTUP) begin
                clock_enable_n_on <= 1'b0;
                pgood_rel <= 1'b0;
                pg_timer  <= 23'h0;
            end else if (mode == MODE_BOOT_WAIT) begin
                if (cpu_profile && timer >= 23'(CLOCK_ENABLE_N_CYC))
                    clock_enable_n_on <= 1'b1;
                if (!cpu_profile && timer >= 23'(PGOOD_GFX_CYC))
                    pgood_rel <= 1'b1;
            end else if (mode == MODE_RUN && cpu_profile) begin
                if (pg_timer >= 23'(PGOOD_CPU_CYC))
                    pgood_rel <= 1'b1;
                else
                    pg_timer <= pg_timer + 23'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // drive mode, blanking, thresholds
    // ------------------------------------------------------------
    logic skip_now;
    logic skip_prev;
    logic stop_prev;
    logic blank_start;

    // slow exit blanks too: a new transition starts there as well
    assign blank_start = (skip_now && !skip_prev)
                         || (mode == MODE_RUN && cpu_profile && !stop_prev
                             && deep_sleep_request && deep_stop_request);

    always_comb begin
        skip_now = 1'b0;
        unique case (mode)
            MODE_STARTUP, MODE_BOOT_WAIT: skip_now = 1'b1;
            MODE_RUN: skip_now = deep_sleep_request;
            default:  skip_now = 1'b0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            skip_prev  <= 1'b0;
            stop_prev  <= 1'b0;
            skip_blank <= 1'b0;
        end else if (clk_en) begin
            skip_prev <= skip_now;
            stop_prev <= deep_stop_request;
            if (blank_start)
                skip_blank <= 1'b1;
            else if (in_regulation)
                skip_blank <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_cfg <= '0;
        end else if (clk_en) begin
            drive_cfg.skip_mode     <= skip_now;
            drive_cfg.zero_cross_en <= skip_now;
            drive_cfg.upper_blank   <= blank_start
                                       || (skip_blank && !in_regulation);
            drive_cfg.ovp_fixed     <= (skip_blank && !in_regulation)
                                       || mode != MODE_RUN;
            if (mode == MODE_RUN && deep_sleep_request
                && deep_stop_request && cpu_profile)
                drive_cfg.slew_div <= `SLEW_DIV_QUARTER;
            else if (mode == MODE_RUN)
                drive_cfg.slew_div <= `SLEW_DIV_NOMINAL;
            else
                drive_cfg.slew_div <= `SLEW_DIV_EIGHTH;
            if (skip_blank && !in_regulation)
                start_target_mv <= cpu_profile ? `OVP_FIXED_CPU_MV
                                               : `OVP_FIXED_GFX_MV;
            else
                start_target_mv <= `BOOT_VOLTAGE_MV;
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    logic active;
    assign active = mode == MODE_STARTUP || mode == MODE_BOOT_WAIT
                    || mode == MODE_RUN || mode == MODE_SHUTDOWN;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power_en <= '0;
        end else if (clk_en) begin
            power_en.ref_enable    <= mode != MODE_DISABLED
                                      && mode != MODE_FAULT
                                      && !supply_lockout;
            power_en.analog_enable <= ref_up || active;
            power_en.pwm_enable    <= active;
            power_en.discharge     <= supply_lockout;
        end
    end

    always_comb begin
        high_side_gate = 1'b0;
        low_side_gate  = 1'b0;
        if (active && !supply_lockout) begin
            high_side_gate = pwm_high_req;
            low_side_gate  = !pwm_high_req
                             && !(drive_cfg.zero_cross_en && zero_current);
        end
    end

    // power-good is open drain: drive low unless released and upper blanking is off
    assign power_good_out  = 1'b0;
    assign power_good_oe   = !pgood_rel || drive_cfg.upper_blank;
    assign clock_enable_n  = !clock_enable_n_on;
    assign clock_enable_oe = clock_enable_n_on && shutdown_n;

endmodule

`default_nettype wire

// file: pkg/regulator_mode_sequencer_defines.svh
`ifndef REGULATOR_MODE_SEQUENCER_DEFINES_SVH
`define REGULATOR_MODE_SEQUENCER_DEFINES_SVH

// ------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------
`define REG_CTRL_ADDR       8'h00
`define REG_STATUS_ADDR     8'h04
`define REG_THRESH_ADDR     8'h08
`define REG_CTRL_RESET      32'h0000_0000

// ctrl fields
`define CTRL_NO_FAULT_BIT   0
`define CTRL_FAULT_CLR_BIT  1

// ------------------------------------------------------------
// slew divisors and thresholds
// ------------------------------------------------------------
`define SLEW_DIV_NOMINAL    4'h1
`define SLEW_DIV_QUARTER    4'h4
`define SLEW_DIV_EIGHTH     4'h8
`define OVP_FIXED_CPU_MV    16'd1800
`define OVP_FIXED_GFX_MV    16'd1550
`define BOOT_VOLTAGE_MV     16'd1200

// ------------------------------------------------------------
// timing: figures in ns, counts at 40 ns clock
// ------------------------------------------------------------
`define CLK_PERIOD_NS       40
`define ANALOG_DELAY_NS     50000
`define CLOCK_ENABLE_N_DELAY_NS      60000
`define PGOOD_CPU_DELAY_NS  5000000
`define PGOOD_GFX_DELAY_NS  60000
`define REF_DELAY_NS        1000
`define REF_DELAY_CYC       ((`REF_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ANALOG_DELAY_CYC    ((`ANALOG_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLOCK_ENABLE_N_DELAY_CYC     ((`CLOCK_ENABLE_N_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PGOOD_CPU_DELAY_CYC ((`PGOOD_CPU_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PGOOD_GFX_DELAY_CYC ((`PGOOD_GFX_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: pkg/regulator_mode_sequencer_pkg.sv
package regulator_mode_sequencer_pkg;

    typedef enum logic [7:0] {
        MODE_DISABLED  = 8'h01,
        MODE_POWERUP   = 8'h02,
        MODE_STARTUP   = 8'h04,
        MODE_BOOT_WAIT = 8'h08,
        MODE_RUN       = 8'h10,
        MODE_SHUTDOWN  = 8'h20,
        MODE_FAULT     = 8'h40
    } reg_mode_t;

    typedef struct packed {
        logic skip_mode;
        logic zero_cross_en;
        logic [3:0] slew_div;
        logic upper_blank;
        logic ovp_fixed;
    } drive_cfg_t;

    typedef struct packed {
        logic undervoltage_trip;
        logic overvoltage_trip;
        logic thermal_trip;
        logic on_time_open;
    } fault_in_t;

    typedef struct packed {
        logic ref_enable;
        logic analog_enable;
        logic pwm_enable;
        logic discharge;
    } power_en_t;

endpackage

// file: bench/regulator_mode_sequencer_sva.sv
`include "regulator_mode_sequencer_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module regulator_mode_sequencer_sva
    import regulator_mode_sequencer_pkg::*;
#(
    parameter int unsigned PGOOD_CPU_CYC = 20
) (
    input wire logic                                hclk,
    input wire logic                                hresetn,
    input wire logic                                shutdown_n,
    input wire logic                                profile_select,
    input wire logic                                supply_lockout,
    input wire logic                                in_regulation,
    input wire logic                                zero_current,
    input wire logic                                high_side_gate,
    input wire logic                                low_side_gate,
    input wire logic                                power_good_oe,
    input wire logic                                clock_enable_n,
    input wire logic                                clock_enable_oe,
    input wire regulator_mode_sequencer_pkg::drive_cfg_t drive_cfg,
    input wire regulator_mode_sequencer_pkg::power_en_t  power_en,
    input wire logic [15:0]                         start_target_mv,
    input wire regulator_mode_sequencer_pkg::reg_mode_t  mode
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    localparam int PG_LO = PGOOD_CPU_CYC - 2;
    localparam int PG_HI = PGOOD_CPU_CYC + 3;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    gates_off_a: assert property (
        mode == MODE_DISABLED |-> !low_side_gate && !high_side_gate)
        else $error("gate driven while disabled");
    skip_cut_a: assert property (
        drive_cfg.skip_mode && zero_current |-> !low_side_gate)
        else $error("low gate on at zero current in skip");
    ovp_fix_a: assert property (
        mode == MODE_RUN && $past(mode) == MODE_RUN
        && drive_cfg.ovp_fixed && profile_select
        |-> start_target_mv == `OVP_FIXED_CPU_MV)
        else $error("wrong fixed overvoltage level");
    track_back_a: assert property (
        (mode == MODE_RUN && in_regulation) [*3]
        |-> !drive_cfg.upper_blank && !drive_cfg.ovp_fixed)
        else $error("thresholds not tracking in regulation");
    soft_start_a: assert property (
        mode == MODE_STARTUP && $past(mode) == MODE_STARTUP
        |-> drive_cfg.skip_mode && drive_cfg.slew_div == `SLEW_DIV_EIGHTH)
        else $error("soft-start drive wrong");
    soft_stop_a: assert property (
        mode == MODE_SHUTDOWN && $past(mode) == MODE_SHUTDOWN
        |-> !drive_cfg.skip_mode && drive_cfg.slew_div == `SLEW_DIV_EIGHTH)
        else $error("soft-shutdown drive wrong");
    pwm_comp_a: assert property (
        mode == MODE_RUN && !drive_cfg.skip_mode && !supply_lockout
        |-> !drive_cfg.zero_cross_en && low_side_gate != high_side_gate)
        else $error("forced pwm gates not complementary");
    pg_drop_a: assert property (
        $fell(shutdown_n) && mode == MODE_RUN |-> ##[1:2]
        (power_good_oe && !clock_enable_oe && mode == MODE_SHUTDOWN))
        else $error("power good not pulled on shutdown");
    ref_order_a: assert property (
        $rose(power_en.pwm_enable)
        |-> power_en.ref_enable && $past(power_en.analog_enable, 8))
        else $error("enable order wrong");
    lockout_a: assert property (
        supply_lockout ##1 supply_lockout |-> !high_side_gate
        && !low_side_gate && power_en.discharge && !power_en.ref_enable)
        else $error("lockout not honoured");
    fault_hold_a: assert property (
        mode == MODE_FAULT && shutdown_n |=> mode == MODE_FAULT)
        else $error("fault left without toggle");
    pg_cpu_a: assert property (
        $fell(clock_enable_n) && profile_select
        |-> ##[PG_LO:PG_HI] !power_good_oe)
        else $error("power good release late");
endmodule

bind regulator_mode_sequencer regulator_mode_sequencer_sva #(
    .PGOOD_CPU_CYC(PGOOD_CPU_CYC)
) chk (.*);

`default_nettype wire

// file: bench/analog_plant_model.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// output stage stand-in: ramps take RAMP cycles
// ------------------------------------------------------------
module analog_plant_model
    import regulator_mode_sequencer_pkg::*;
#(
    parameter int RAMP = 12
) (
    input  wire logic                                hclk,
    input  wire logic                                hresetn,
    input  wire regulator_mode_sequencer_pkg::power_en_t power_en,
    input  wire regulator_mode_sequencer_pkg::reg_mode_t mode,
    output logic                                     at_target,
    output logic                                     at_zero,
    output logic                                     pwm_high_req
);
    int up_cnt;
    int down_cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up_cnt <= 0;
            down_cnt <= 0;
            pwm_high_req <= 1'b0;
        end else begin
            up_cnt <= !power_en.pwm_enable ? 0 : (up_cnt < RAMP ? up_cnt + 1 : RAMP);
            down_cnt <= mode != MODE_SHUTDOWN ? 0 : (down_cnt < RAMP ? down_cnt + 1 : RAMP);
            pwm_high_req <= power_en.pwm_enable && !pwm_high_req;
        end
    end
    assign at_target = up_cnt == RAMP && mode != MODE_SHUTDOWN;
    assign at_zero = down_cnt == RAMP;
endmodule

`default_nettype wire

// file: bench/tb_top.sv
`include "regulator_mode_sequencer_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import regulator_mode_sequencer_pkg::*;
    localparam int ANA = 10, CKE = 10, PGC = 20, PGG = 10;
    logic        hclk, hresetn, clk_en, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic        shutdown_n, deep_sleep_request, deep_stop_request;
    logic        profile_select, supply_lockout, at_target, at_zero;
    logic        in_regulation, zero_current, pwm_high_req;
    logic        high_side_gate, low_side_gate, power_good_out, power_good_oe;
    logic        clock_enable_n, clock_enable_oe;
    logic [15:0] start_target_mv;
    fault_in_t   faults;
    drive_cfg_t  drive_cfg;
    power_en_t   power_en;
    reg_mode_t   mode;
    int          mismatches, compares, n;

    assign hready = hreadyout;
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    regulator_mode_sequencer #(.ANALOG_CYC(ANA), .CLOCK_ENABLE_N_CYC(CKE),
        .PGOOD_CPU_CYC(PGC), .PGOOD_GFX_CYC(PGG)) dut (.*);
    analog_plant_model plant (.*);

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task step(input int k);
        repeat (k) @(posedge hclk);
    endtask
    task wait_mode(input reg_mode_t m);
        for (n = 0; mode !== m && n < 3000; n++) @(posedge hclk);
    endtask
    task automatic wait_low(ref logic s);
        for (n = 0; s !== 1'b0 && n < 3000; n++) @(posedge hclk);
    endtask
    task wrap_up;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        step(20000);
        mismatches++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {hresetn, hsel, htrans, haddr, hwrite, hwdata} = '0;
        {deep_sleep_request, deep_stop_request, supply_lockout} = '0;
        {shutdown_n, in_regulation, zero_current, faults} = '0;
        {clk_en, profile_select, hsize} = {2'b11, 3'b010};
        step(4);
        hresetn <= 1'b1;
        @(negedge hclk);
        check(32'(mode), 32'(MODE_DISABLED));
        check(32'({clock_enable_n, power_good_oe, low_side_gate}), 32'h6);
        xfer(1'b1, 8'h0c, 32'hffff_ffff);
        xfer(1'b0, 8'h0c, 32'h0);
        check(rd, 32'h0);
        xfer(1'b0, `REG_CTRL_ADDR, 32'h0);
        check(rd, `REG_CTRL_RESET);
        $display("test reset and bus done");

        shutdown_n <= 1'b1;
        wait_mode(MODE_STARTUP);
        check(32'(n >= ANA && n <= ANA + 4), 32'h1);
        @(negedge hclk);
        check(32'(power_en), 32'he);
        check(32'({drive_cfg.skip_mode, drive_cfg.slew_div}), 32'h18);
        xfer(1'b0, `REG_THRESH_ADDR, 32'h0);
        check(32'(rd[19:16]), 32'(`SLEW_DIV_EIGHTH));
        wait_mode(MODE_BOOT_WAIT);
        in_regulation <= 1'b1;
        wait_low(clock_enable_n);
        check(32'(n >= CKE - 1 && n <= CKE + 3), 32'h1);
        wait_low(power_good_oe);
        check(32'(n >= PGC - 2 && n <= PGC + 3), 32'h1);
        wait_mode(MODE_RUN);
        @(negedge hclk);
        check(32'({drive_cfg.skip_mode, drive_cfg.zero_cross_en,
            drive_cfg.slew_div}), 32'h01);
        $display("test cpu power-up done");

        @(posedge hclk);
        deep_sleep_request <= 1'b1;
        in_regulation <= 1'b0;
        step(3);
        check(32'({drive_cfg.skip_mode, drive_cfg.slew_div,
            drive_cfg.upper_blank}), 32'h23);
        check(32'(start_target_mv), 32'(`OVP_FIXED_CPU_MV));
        zero_current <= 1'b1;
        @(negedge hclk);
        check(32'(low_side_gate), 32'h0);
        @(posedge hclk);
        zero_current <= 1'b0;
        in_regulation <= 1'b1;
        step(4);
        check(32'({drive_cfg.upper_blank, drive_cfg.ovp_fixed}), 32'h0);
        in_regulation <= 1'b0;
        deep_stop_request <= 1'b1;
        step(3);
        check(32'({drive_cfg.skip_mode, drive_cfg.slew_div,
            drive_cfg.upper_blank}), 32'h29);
        deep_stop_request <= 1'b0;
        in_regulation <= 1'b1;
        $display("test deep sleep done");

        shutdown_n <= 1'b0;
        step(3);
        check(32'({power_good_oe, clock_enable_oe}), 32'h2);
        check(32'({drive_cfg.skip_mode, drive_cfg.slew_div}), 32'h08);
        wait_mode(MODE_DISABLED);
        check(32'(n <= 20), 32'h1);
        @(negedge hclk);
        check(32'({high_side_gate, low_side_gate}), 32'h0);
        $display("test shutdown done");

        @(posedge hclk);
        deep_sleep_request <= 1'b0;
        profile_select <= 1'b0;
        step(2);
        shutdown_n <= 1'b1;
        wait_mode(MODE_STARTUP);
        faults.undervoltage_trip <= 1'b1;
        @(posedge hclk);
        faults.undervoltage_trip <= 1'b0;
        wait_mode(MODE_FAULT);
        check(32'(n <= 3), 32'h1);
        step(20);
        check(32'(mode), 32'(MODE_FAULT));
        xfer(1'b0, `REG_STATUS_ADDR, 32'h0);
        check(32'(rd[15]), 32'h1);
        shutdown_n <= 1'b0;
        step(2);
        shutdown_n <= 1'b1;
        wait_mode(MODE_BOOT_WAIT);
        check(32'(n < 100), 32'h1);
        wait_low(power_good_oe);
        check(32'(n >= PGG - 2 && n <= PGG + 3), 32'h1);
        $display("test fault and graphics done");

        wait_mode(MODE_RUN);
        supply_lockout <= 1'b1;
        step(3);
        check(32'(mode), 32'(MODE_DISABLED));
        check(32'({power_en, high_side_gate, low_side_gate}), 32'h4);
        supply_lockout <= 1'b0;
        shutdown_n <= 1'b0;
        step(4);
        $display("test lockout done");
        wrap_up();
    end
endmodule

`default_nettype wire
